// File: include/ext_mem_op_map.vh
// register offsets, field layouts, reset values and operation codes of the extended memory-op datapath
`ifndef EXT_MEM_OP_MAP_VH
`define EXT_MEM_OP_MAP_VH

// apb byte offsets
`define OFS_CTRL 8'h00
`define OFS_ACC 8'h04
`define OFS_STATUS 8'h08
`define OFS_INFO 8'h0C
`define OFS_MEM_PTR 8'h10
`define OFS_MEM_DATA 8'h14

// control word fields
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 4
`define CTRL_BIT_LSB 5
`define CTRL_BIT_MSB 7
`define CTRL_ADDR_LSB 8
`define CTRL_ADDR_MSB 18

// status flag bit positions
`define FLG_CARRY 0
`define FLG_HALF 1
`define FLG_ZERO 2
`define FLG_WRAP 3
`define FLG_SOUT 4
`define FLG_MNULL 5

// info register bit positions
`define INFO_BUSY 0
`define INFO_SKIP 1
`define INFO_ILLEGAL 2
`define INFO_CYC_LSB 4
`define INFO_CYC_MSB 5

// reset values
`define ACC_RST 8'h00
`define FLAGS_RST 6'h00
`define MEM_PTR_RST 11'h000

// data memory: eight sections of 256 bytes, one flat 11-bit address
`define DMEM_AW 11
`define DMEM_DEPTH 2048

// instruction cycle counts
`define CYC_PLAIN 2'h2
`define CYC_SKIP 2'h3

// operation codes
`define OP_MOVE_TO_ACC 5'h00
`define OP_MOVE_TO_MEM 5'h01
`define OP_OR 5'h02
`define OP_OR_TO_MEM 5'h03
`define OP_ROT_L 5'h04
`define OP_ROT_L_ACC 5'h05
`define OP_ROT_LC 5'h06
`define OP_ROT_LC_ACC 5'h07
`define OP_ROT_R 5'h08
`define OP_ROT_R_ACC 5'h09
`define OP_ROT_RC 5'h0A
`define OP_ROT_RC_ACC 5'h0B
`define OP_SUB_BORROW 5'h0C
`define OP_SUB_BORROW_MEM 5'h0D
`define OP_SUBTRACT 5'h0E
`define OP_SUBTRACT_MEM 5'h0F
`define OP_DEC_SKIP 5'h10
`define OP_DEC_SKIP_ACC 5'h11
`define OP_SET_ONES 5'h12
`define OP_SET_BIT 5'h13
`define OP_INC_SKIP 5'h14
`define OP_INC_SKIP_ACC 5'h15
`define OP_SKIP_BIT_SET 5'h16
`define OP_SKIP_NONNULL 5'h17

`endif

// File: rtl/extended_memory_op_execute.v
// extended memory-op execute datapath with apb command and register port
// Operation
// - wide move loads memory byte, flags untouched
// - wide move stores accumulator, flags untouched
// - or into acc or memory, zero only
// - rotate left, bit7 into bit0, no flags
// - rotate left through carry bit
// - rotate right, bit0 into bit7, no flags
// - rotate right through carry bit
// - acc rotates leave memory, carry forms still update carry
// - subtract updates six arithmetic flags
// - carry clear if negative, else set
// - borrow subtract also removes inverted carry
// - memory variants write result to memory
// - decrement memory, skip when zero
// - decrement into acc, skip when zero
// - increment memory, skip when zero
// - increment into acc, skip when zero
// - taken skip adds dummy third cycle
// - set ones writes all-ones byte
// - set bit affects only chosen bit
// - skip when selected bit is one
// - byte test rewrites byte, skips nonzero
// - flat address reaches every memory section
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "ext_mem_op_map.vh"

module extended_memory_op_execute (
   input wire REF_CLK,
   input wire RST_N,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   output reg BUSY,
   output reg INSTR_DONE,
   output reg SKIP_TAKEN,
   output reg DUMMY_SLOT
);

   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_FETCH = 2'h1;
   localparam [1:0] ST_EXEC = 2'h2;
   localparam [1:0] ST_DUMMY = 2'h3;

   reg [7:0] dmem [0:`DMEM_DEPTH-1];

   reg [1:0] state_q;
   reg [7:0] acc_q;
   reg [5:0] flags_q;
   reg [4:0] op_q;
   reg [2:0] bit_q;
   reg [`DMEM_AW-1:0] addr_q;
   reg [`DMEM_AW-1:0] mem_ptr_q;
   reg [7:0] opnd_q;
   reg last_skip_q;
   reg illegal_q;
   reg [1:0] cycles_q;

   // alu results
   reg [7:0] res_d;
   reg [5:0] flags_d;
   reg wr_acc_d;
   reg wr_mem_d;
   reg skip_d;
   reg bad_op_d;
   reg [8:0] diff9;
   reg [4:0] diff5;
   reg borrow_in;

   wire [7:0] bit_mask;
   wire setup_ph;
   wire access_done;
   wire start_cmd;
   wire sw_mem_wr;
   wire busy_now;

   // one-hot bit select, built per bit position
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_mask
         assign bit_mask[gi] = ({29'h0000000, bit_q} == gi);
      end
   endgenerate

   assign busy_now = (state_q != ST_IDLE);
   assign setup_ph = PSEL & ~PENABLE;
   assign access_done = PSEL & PENABLE & PREADY;
   assign start_cmd = access_done & PWRITE & ~PSLVERR & (PADDR == `OFS_CTRL);
   assign sw_mem_wr = access_done & PWRITE & ~PSLVERR & (PADDR == `OFS_MEM_DATA);

   always @* begin
      res_d = opnd_q;
      flags_d = flags_q;
      wr_acc_d = 1'b0;
      wr_mem_d = 1'b0;
      skip_d = 1'b0;
      bad_op_d = 1'b0;
      borrow_in = 1'b0;
      if (op_q == `OP_SUB_BORROW || op_q == `OP_SUB_BORROW_MEM) begin
         borrow_in = ~flags_q[`FLG_CARRY];
      end
      diff9 = {1'b0, acc_q} - {1'b0, opnd_q} - {8'h00, borrow_in};
      diff5 = {1'b0, acc_q[3:0]} - {1'b0, opnd_q[3:0]} - {4'h0, borrow_in};
      case (op_q)
         `OP_MOVE_TO_ACC: begin
            res_d = opnd_q;
            wr_acc_d = 1'b1;
         end
         `OP_MOVE_TO_MEM: begin
            res_d = acc_q;
            wr_mem_d = 1'b1;
         end
         `OP_OR, `OP_OR_TO_MEM: begin
            res_d = acc_q | opnd_q;
            flags_d[`FLG_ZERO] = (res_d == 8'h00);
            wr_acc_d = (op_q == `OP_OR);
            wr_mem_d = (op_q == `OP_OR_TO_MEM);
         end
         `OP_ROT_L, `OP_ROT_L_ACC: begin
            res_d = {opnd_q[6:0], opnd_q[7]};
            wr_acc_d = (op_q == `OP_ROT_L_ACC);
            wr_mem_d = (op_q == `OP_ROT_L);
         end
         `OP_ROT_LC, `OP_ROT_LC_ACC: begin
            res_d = {opnd_q[6:0], flags_q[`FLG_CARRY]};
            flags_d[`FLG_CARRY] = opnd_q[7];
            wr_acc_d = (op_q == `OP_ROT_LC_ACC);
            wr_mem_d = (op_q == `OP_ROT_LC);
         end
         `OP_ROT_R, `OP_ROT_R_ACC: begin
            res_d = {opnd_q[0], opnd_q[7:1]};
            wr_acc_d = (op_q == `OP_ROT_R_ACC);
            wr_mem_d = (op_q == `OP_ROT_R);
         end
         `OP_ROT_RC, `OP_ROT_RC_ACC: begin
            res_d = {flags_q[`FLG_CARRY], opnd_q[7:1]};
            flags_d[`FLG_CARRY] = opnd_q[0];
            wr_acc_d = (op_q == `OP_ROT_RC_ACC);
            wr_mem_d = (op_q == `OP_ROT_RC);
         end
         `OP_SUB_BORROW, `OP_SUB_BORROW_MEM, `OP_SUBTRACT, `OP_SUBTRACT_MEM: begin
            res_d = diff9[7:0];
            flags_d[`FLG_CARRY] = ~diff9[8];
            flags_d[`FLG_HALF] = ~diff5[4];
            flags_d[`FLG_ZERO] = (diff9[7:0] == 8'h00);
            flags_d[`FLG_WRAP] = (acc_q[7] ^ opnd_q[7]) & (diff9[7] ^ acc_q[7]);
            // sign of the true nine-bit result, valid even when the byte wraps
            flags_d[`FLG_SOUT] = diff9[7] ^ flags_d[`FLG_WRAP];
            // borrow form chains the null test across a multi-byte subtract
            if (op_q == `OP_SUB_BORROW || op_q == `OP_SUB_BORROW_MEM) begin
               flags_d[`FLG_MNULL] = flags_d[`FLG_ZERO] & flags_q[`FLG_MNULL];
            end else begin
               flags_d[`FLG_MNULL] = flags_d[`FLG_ZERO];
            end
            wr_acc_d = (op_q == `OP_SUB_BORROW) || (op_q == `OP_SUBTRACT);
            wr_mem_d = (op_q == `OP_SUB_BORROW_MEM) || (op_q == `OP_SUBTRACT_MEM);
         end
         `OP_DEC_SKIP, `OP_DEC_SKIP_ACC: begin
            res_d = opnd_q - 8'h01;
            skip_d = (res_d == 8'h00);
            wr_acc_d = (op_q == `OP_DEC_SKIP_ACC);
            wr_mem_d = (op_q == `OP_DEC_SKIP);
         end
         `OP_INC_SKIP, `OP_INC_SKIP_ACC: begin
            res_d = opnd_q + 8'h01;
            skip_d = (res_d == 8'h00);
            wr_acc_d = (op_q == `OP_INC_SKIP_ACC);
            wr_mem_d = (op_q == `OP_INC_SKIP);
         end
         `OP_SET_ONES: begin
            res_d = 8'hFF;
            wr_mem_d = 1'b1;
         end
         `OP_SET_BIT: begin
            res_d = opnd_q | bit_mask;
            wr_mem_d = 1'b1;
         end
         `OP_SKIP_BIT_SET: begin
            skip_d = |(opnd_q & bit_mask);
         end
         `OP_SKIP_NONNULL: begin
            res_d = opnd_q;
            wr_mem_d = 1'b1;
            skip_d = (opnd_q != 8'h00);
         end
         default: begin
            bad_op_d = 1'b1;
         end
      endcase
   end

   // instruction sequencer
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         op_q <= 5'h00;
         bit_q <= 3'h0;
         addr_q <= {`DMEM_AW{1'b0}};
         opnd_q <= 8'h00;
         last_skip_q <= 1'b0;
         illegal_q <= 1'b0;
         cycles_q <= 2'h0;
         BUSY <= 1'b0;
         INSTR_DONE <= 1'b0;
         SKIP_TAKEN <= 1'b0;
         DUMMY_SLOT <= 1'b0;
      end else begin
         INSTR_DONE <= 1'b0;
         SKIP_TAKEN <= 1'b0;
         DUMMY_SLOT <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (start_cmd) begin
                  op_q <= PWDATA[`CTRL_OP_MSB:`CTRL_OP_LSB];
                  bit_q <= PWDATA[`CTRL_BIT_MSB:`CTRL_BIT_LSB];
                  addr_q <= PWDATA[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
                  state_q <= ST_FETCH;
                  BUSY <= 1'b1;
               end
            end
            ST_FETCH: begin
               opnd_q <= dmem[addr_q];
               state_q <= ST_EXEC;
            end
            ST_EXEC: begin
               last_skip_q <= skip_d;
               illegal_q <= bad_op_d;
               if (skip_d) begin
                  state_q <= ST_DUMMY;
                  SKIP_TAKEN <= 1'b1;
                  DUMMY_SLOT <= 1'b1;
                  cycles_q <= `CYC_SKIP;
               end else begin
                  state_q <= ST_IDLE;
                  INSTR_DONE <= 1'b1;
                  BUSY <= 1'b0;
                  cycles_q <= `CYC_PLAIN;
               end
            end
            ST_DUMMY: begin
               state_q <= ST_IDLE;
               INSTR_DONE <= 1'b1;
               BUSY <= 1'b0;
            end
            default: begin
               state_q <= ST_IDLE;
               BUSY <= 1'b0;
            end
         endcase
      end
   end

   // accumulator and flags; software writes are refused while busy so no clash arises
   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         acc_q <= `ACC_RST;
         flags_q <= `FLAGS_RST;
         mem_ptr_q <= `MEM_PTR_RST;
      end else begin
         if (state_q == ST_EXEC) begin
            flags_q <= flags_d;
            if (wr_acc_d) begin
               acc_q <= res_d;
            end
         end else if (access_done & PWRITE & ~PSLVERR) begin
            if (PADDR == `OFS_ACC) begin
               acc_q <= PWDATA[7:0];
            end
            if (PADDR == `OFS_STATUS) begin
               flags_q <= PWDATA[5:0];
            end
         end
         // the pointer stays writable while busy, so it must not sit behind the execute branch
         if (access_done & PWRITE & ~PSLVERR & (PADDR == `OFS_MEM_PTR)) begin
            mem_ptr_q <= PWDATA[`DMEM_AW-1:0];
         end
      end
   end

   // single write port: core writeback or software through the pointer window
   always @(posedge REF_CLK) begin
      if (state_q == ST_EXEC && wr_mem_d) begin
         dmem[addr_q] <= res_d;
      end else if (sw_mem_wr) begin
         dmem[mem_ptr_q] <= PWDATA[7:0];
      end
   end

   // apb slave: answer registered in the setup cycle, so every access takes one access cycle
   reg [31:0] rd_mux;
   reg err_d;
   always @* begin
      rd_mux = 32'h00000000;
      err_d = 1'b0;
      case (PADDR)
         `OFS_CTRL: begin
            rd_mux = {13'h0000, addr_q, bit_q, op_q};
            err_d = PWRITE & busy_now;
         end
         `OFS_ACC: begin
            rd_mux = {24'h000000, acc_q};
            err_d = PWRITE & busy_now;
         end
         `OFS_STATUS: begin
            rd_mux = {26'h0000000, flags_q};
            err_d = PWRITE & busy_now;
         end
         `OFS_INFO: begin
            rd_mux[`INFO_BUSY] = busy_now;
            rd_mux[`INFO_SKIP] = last_skip_q;
            rd_mux[`INFO_ILLEGAL] = illegal_q;
            rd_mux[`INFO_CYC_MSB:`INFO_CYC_LSB] = cycles_q;
            err_d = PWRITE;
         end
         `OFS_MEM_PTR: begin
            rd_mux = {21'h000000, mem_ptr_q};
         end
         `OFS_MEM_DATA: begin
            rd_mux = {24'h000000, dmem[mem_ptr_q]};
            err_d = PWRITE & busy_now;
         end
         default: begin
            err_d = 1'b1;
         end
      endcase
   end

   always @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         PRDATA <= 32'h00000000;
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= setup_ph;
         if (setup_ph) begin
            PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
            PSLVERR <= err_d;
         end else if (access_done) begin
            PSLVERR <= 1'b0;
         end
      end
   end

endmodule // extended_memory_op_execute

`default_nettype wire

// File: test/ext_mem_op_assertions.sv
// port-level checks of the extended memory-op datapath
`timescale 1ns/10ps
`default_nettype none
`include "ext_mem_op_map.vh"
module ext_mem_op_checker (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic BUSY,
   input wire logic INSTR_DONE,
   input wire logic SKIP_TAKEN,
   input wire logic DUMMY_SLOT
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_N);
   sequence s_wr_done;
      PSEL && PENABLE && PREADY && PWRITE;
   endsequence
   sequence s_start;
      s_wr_done ##0 (PADDR == `OFS_CTRL && !PSLVERR && !BUSY);
   endsequence
   sequence s_run;
      BUSY ##1 BUSY ##1 (INSTR_DONE || SKIP_TAKEN);
   endsequence
   a_start_runs: assert property (s_start |=> s_run) else $error("instruction timing off");
   a_ready_first: assert property ($rose(PENABLE) && PSEL |-> PREADY) else $error("no ready in first access");
   a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
   a_done_pulse: assert property (INSTR_DONE |-> !BUSY ##1 !INSTR_DONE) else $error("done not a pulse");
   a_busy_end: assert property ($fell(BUSY) |-> INSTR_DONE) else $error("busy fell without done");
   a_skip_dummy: assert property (SKIP_TAKEN |-> DUMMY_SLOT ##1 (INSTR_DONE && !DUMMY_SLOT)) else $error("no third cycle");
   a_dummy_cause: assert property (DUMMY_SLOT |-> SKIP_TAKEN && $past(BUSY)) else $error("stray dummy");
   a_info_ro: assert property (s_wr_done ##0 PADDR == `OFS_INFO |-> PSLVERR) else $error("info write taken");
   a_ctrl_busy: assert property (s_wr_done ##0 (PADDR == `OFS_CTRL && BUSY && $past(BUSY)) |-> PSLVERR)
      else $error("ctrl write taken while busy");
endmodule // ext_mem_op_checker
bind extended_memory_op_execute ext_mem_op_checker u_chk (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .BUSY(BUSY), .INSTR_DONE(INSTR_DONE), .SKIP_TAKEN(SKIP_TAKEN), .DUMMY_SLOT(DUMMY_SLOT));
`default_nettype wire

// File: test/apb_master.sv
// apb master standing in for the software host
`timescale 1ns/10ps
`default_nettype none
module apb_master (
   input wire logic clk,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
   end
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released bus shows inverted values so a slave latching late sees garbage
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule // apb_master
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench of the extended memory-op datapath
`timescale 1ns/10ps
`default_nettype none
`include "ext_mem_op_map.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   wire logic psel, penable, pwrite, pready, pslverr, busy, instr_done, skip_taken, dummy_slot;
   wire logic [7:0] paddr;
   wire logic [31:0] pwdata, prdata;
   int n_mismatch = 0;
   int n_tests = 0;
   int seed = 85;
   logic [31:0] rd;
   logic err;
   logic [7:0] acc;
   always #2 ref_clk = ~ref_clk;
   extended_memory_op_execute u_extended_memory_op_execute (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .BUSY(busy), .INSTR_DONE(instr_done), .SKIP_TAKEN(skip_taken), .DUMMY_SLOT(dummy_slot));
   apb_master u_apb_master (.clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_apb_master.xfer(w, a, d, rd, err);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic run_op(input int op);
      logic [7:0] a, m, r;
      logic [5:0] f;
      logic [8:0] d9;
      logic [10:0] ad;
      logic sk, ske;
      int b, n;
      ad = $random(seed);
      b = $random(seed) & 7;
      a = $random(seed);
      f = $random(seed);
      case ($random(seed) & 3)
         0: m = 8'h00;
         1: m = 8'hFF;
         2: m = 8'h01;
         default: m = $random(seed);
      endcase
      bus(1'b1, `OFS_MEM_PTR, {21'h0, ad});
      bus(1'b1, `OFS_MEM_DATA, {24'h0, m});
      bus(1'b1, `OFS_ACC, {24'h0, a});
      bus(1'b1, `OFS_STATUS, {26'h0, f});
      bus(1'b1, `OFS_CTRL, {13'h0, ad, b[2:0], op[4:0]});
      r = m;
      ske = 1'b0;
      case (op)
         0: a = m;
         1: r = a;
         2, 3: r = a | m;
         4, 5: r = {m[6:0], m[7]};
         6, 7: begin
            r = {m[6:0], f[`FLG_CARRY]};
            f[`FLG_CARRY] = m[7];
         end
         8, 9: r = {m[0], m[7:1]};
         10, 11: begin
            r = {f[`FLG_CARRY], m[7:1]};
            f[`FLG_CARRY] = m[0];
         end
         12, 13, 14, 15: begin
            b = (op < 14) ? !f[`FLG_CARRY] : 0;
            d9 = {1'b0, a} - {1'b0, m} - 9'(b);
            r = d9[7:0];
            f[`FLG_WRAP] = (a[7] != m[7]) && (r[7] != a[7]);
            f[`FLG_HALF] = {1'b0, a[3:0]} >= ({1'b0, m[3:0]} + 5'(b));
            f[`FLG_CARRY] = !d9[8];
            f[`FLG_SOUT] = r[7] ^ f[`FLG_WRAP];
            f[`FLG_MNULL] = (r == 8'h00) && (op > 13 || f[`FLG_MNULL]);
         end
         16, 17: r = m - 8'h01;
         18: r = 8'hFF;
         19: r[b] = 1'b1;
         20, 21: r = m + 8'h01;
         22: ske = m[b];
         23: ske = (m != 8'h00);
         default: ;
      endcase
      if (op inside {[16:17], [20:21]})
         ske = (r == 8'h00);
      if (op inside {2, 3, [12:15]})
         f[`FLG_ZERO] = (r == 8'h00);
      if (op inside {2, 5, 7, 9, 11, 12, 14, 17, 21})
         a = r;
      else
         m = r;
      n = 0;
      sk = 1'b0;
      do begin
         @(posedge ref_clk);
         n++;
         if (skip_taken === 1'b1)
            sk = 1'b1;
      end while (instr_done !== 1'b1 && n < 8);
      `CHK("skip", ske, sk)
      `CHK("cycles", ske ? 4 : 3, n)
      bus(1'b0, `OFS_ACC, 32'h0);
      `CHK("acc", {24'h0, a}, rd)
      bus(1'b0, `OFS_STATUS, 32'h0);
      `CHK("flags", {26'h0, f}, rd)
      bus(1'b0, `OFS_MEM_DATA, 32'h0);
      `CHK("mem", {24'h0, m}, rd)
      bus(1'b0, `OFS_INFO, 32'h0);
      `CHK("info", {ske ? `CYC_SKIP : `CYC_PLAIN, ske, op > 23}, {rd[5:4], rd[1], rd[2]})
      acc = a;
   endtask
   initial begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      for (int k = 0; k < 75; k++) begin
         run_op(k % 25);
         $display("test %0d op %0d done", k, k % 25);
      end
      bus(1'b1, `OFS_CTRL, {13'h0, 11'h7FF, 3'h0, `OP_SET_ONES});
      bus(1'b1, `OFS_ACC, 32'h0000005A);
      `CHK("busy refuse", 1'b1, err)
      bus(1'b1, `OFS_CTRL, {13'h0, 11'h7FF, 3'h0, `OP_SKIP_NONNULL});
      bus(1'b1, `OFS_CTRL, {13'h0, 11'h7FF, 3'h0, `OP_MOVE_TO_ACC});
      `CHK("ctrl refuse", 1'b1, err)
      for (int i = 0; i < 10 && busy === 1'b1; i++)
         @(posedge ref_clk);
      bus(1'b0, `OFS_ACC, 32'h0);
      `CHK("acc kept", {24'h0, acc}, rd)
      bus(1'b1, `OFS_INFO, 32'h1);
      `CHK("info refuse", 1'b1, err)
      bus(1'b0, 8'h18, 32'h0);
      `CHK("unmapped", {1'b1, 32'h0}, {err, rd})
      $display("test refusals done");
      end_of_test;
   end
   initial begin
      #100000;
      n_mismatch++;
      end_of_test;
   end
endmodule // tb_top
`default_nettype wire
